// ==== rtl/tws_regs.svh ====
// Register offsets, field positions, reset values, status codes and timing of the two-wire slave receiver
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

`define TWS_CTRL_OFS      8'h00
`define TWS_STATUS_OFS    8'h04
`define TWS_DATA_OFS      8'h08
`define TWS_OWNADDR_OFS   8'h0c
`define TWS_POWER_OFS     8'h10

`define TWS_CTRL_FLAG     7
`define TWS_CTRL_ACK      6
`define TWS_CTRL_STA      5
`define TWS_CTRL_STO      4
`define TWS_CTRL_WC       3
`define TWS_CTRL_EN       2
`define TWS_CTRL_IE       0

`define TWS_PWR_SLEEP     0
`define TWS_PWR_WAKE      1

`define TWS_CTRL_RESET    8'h00
`define TWS_OWNADDR_RESET 8'h00
`define TWS_DATA_RESET    8'hff
`define TWS_PRESC_RESET   2'h0

`define TWS_ST_START      8'h08
`define TWS_ST_OWN_ACK    8'h60
`define TWS_ST_ARB_OWN    8'h68
`define TWS_ST_GC_ACK     8'h70
`define TWS_ST_ARB_GC     8'h78
`define TWS_ST_DATA_ACK   8'h80
`define TWS_ST_DATA_NACK  8'h88
`define TWS_ST_GCD_ACK    8'h90
`define TWS_ST_GCD_NACK   8'h98
`define TWS_ST_STOP       8'ha0
`define TWS_ST_IDLE       8'hf8

`define TWS_CLK_NS        100
`define TWS_START_HOLD_NS 4000
`define TWS_START_HOLD_CYC ((`TWS_START_HOLD_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)

`endif

// ==== rtl/tws_pkg.sv ====
// Types shared by the two-wire slave receiver modules
package tws_pkg;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_DATA,
		ST_DATA_ACK,
		ST_WAIT_SVC,
		ST_START_GEN
	} tws_state_t;

endpackage

// ==== rtl/tws_line_if.sv ====
// Synchronised bus line levels and bus events passed from the line monitor to the core
`timescale 1ns/1ns
`default_nettype none

interface tws_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	modport mon
	(
		output scl, sda, scl_rise, scl_fall, start_det, stop_det
	);
	modport core
	(
		input scl, sda, scl_rise, scl_fall, start_det, stop_det
	);
endinterface

`default_nettype wire

// ==== rtl/tws_line_mon.sv ====
// Two-flop synchroniser and edge, START and STOP detection for the bus lines
`timescale 1ns/1ns
`default_nettype none

module tws_line_mon
	import tws_pkg::*;
(
	// Clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// Raw bus lines
	input  wire logic  scl_pin,
	input  wire logic  sda_pin,
	// Toward the core
	tws_line_if.mon    line
);

	logic [2:0] scl_reg;
	logic [2:0] sda_reg;

	// Stage 0 feeds only stage 1; edges are taken from stages 1 and 2
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_reg <= 3'h7;
			sda_reg <= 3'h7;
		end
		else
		begin
			scl_reg <= {scl_reg[1:0], scl_pin};
			sda_reg <= {sda_reg[1:0], sda_pin};
		end
	end

	assign line.scl       = scl_reg[1];
	assign line.sda       = sda_reg[1];
	assign line.scl_rise  = scl_reg[1] & ~scl_reg[2];
	assign line.scl_fall  = ~scl_reg[1] & scl_reg[2];
	assign line.start_det = scl_reg[1] & scl_reg[2] & sda_reg[2] & ~sda_reg[1];
	assign line.stop_det  = scl_reg[1] & scl_reg[2] & ~sda_reg[2] & sda_reg[1];

endmodule

`default_nettype wire

// ==== rtl/tws_slave_rx.sv ====
// Two-wire slave receiver with APB register access and address-match wake-up
//
// Summary of operation
// - Upper seven own-address bits are the slave address that is answered.
// - Own-address bit 0 enables answering the general call address 0x00.
// - Wait for matching address; direction 0 receives, direction 1 is transmitter; here direction 1 is not acknowledged.
// - Own address with write sets the service flag and a valid status.
// - Addressed after lost arbitration reports 0x68 own or 0x78 general call.
// - Acknowledged own address reports 0x60, general call reports 0x70.
// - After flag clear, next byte is received; ACK if acknowledge enable set.
// - Acknowledged data reports 0x80 own or 0x90 general call; byte is readable.
// - Not-acknowledged data reports 0x88 own or 0x98 general call.
// - Servicing a NACK data state returns to the not-addressed state.
// - Start request with that service sends START once the bus is free.
// - Acknowledge enable cleared mid-transfer gives NACK after next data byte.
// - With acknowledge enable clear, bus is still watched; recognition resumes when set.
// - In deep sleep the address is still recognised and the part woken.
// - On wake-up match SCL stays low until the flag is cleared.
// - Writing one clears the service flag; writing zero leaves it.
// - After deep sleep the data register need not hold the last bus byte.
// - Status codes assume prescaler bits zero; software masks them.
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.svh"

module tws_slave_rx
	import tws_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Two-wire bus, open drain
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// Master logic and power control
	input  wire logic        arb_lost,
	output logic             wake_req
);

	tws_line_if line_bus ();

	tws_line_mon u_line_mon
	(
		.pclk    (pclk),
		.presetn (presetn),
		.scl_pin (scl_i),
		.sda_pin (sda_i),
		.line    (line_bus.mon)
	);

	tws_state_t  state_reg;
	logic [7:0]  own_slave_address;
	logic [7:0]  shift_reg;
	logic [7:0]  shift_data_reg;
	logic [4:0]  status_code_reg;
	logic [1:0]  presc_reg;
	logic [3:0]  bit_cnt_reg;
	logic [5:0]  hold_cnt_reg;
	logic        service_flag;
	logic        ack_enable;
	logic        start_request;
	logic        stop_request;
	logic        write_collision_flag;
	logic        iface_enable;
	logic        irq_enable;
	logic        deep_sleep_reg;
	logic        wake_reg;
	logic        gc_reg;
	logic        lost_reg;
	logic        data_ack_reg;
	logic        nack_last_reg;
	logic        mst_reg;
	logic        start_done_reg;
	logic        bus_busy_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rdata;
	logic        addr_ok;
	logic        apb_wr;
	logic        apb_rd;
	logic        flag_clr;
	logic        own_hit;
	logic        gc_hit;
	logic        bus_free;

	// A literal cannot be bit-selected, so the control reset word is named here
	localparam logic [7:0] ctrl_rst_val = `TWS_CTRL_RESET;

	// Zero-wait APB: pready rises in the first access cycle
	assign apb_wr   = psel & penable & pready_reg & pwrite;
	assign apb_rd   = psel & penable & pready_reg & ~pwrite;
	assign flag_clr = apb_wr && paddr == `TWS_CTRL_OFS && pwdata[`TWS_CTRL_FLAG];

	assign own_hit  = ack_enable && shift_reg[7:1] == own_slave_address[7:1];
	assign gc_hit   = ack_enable && own_slave_address[0] && shift_reg[7:1] == 7'h00;
	assign bus_free = !bus_busy_reg && line_bus.scl && line_bus.sda;

	always_comb
	begin
		addr_ok = 1'b1;
		rdata   = 32'h0000_0000;
		case (paddr)
			`TWS_CTRL_OFS:
				rdata[7:0] = {service_flag, ack_enable, start_request, stop_request,
					write_collision_flag, iface_enable, 1'b0, irq_enable};
			`TWS_STATUS_OFS:
				rdata[7:0] = {status_code_reg, 1'b0, presc_reg};
			`TWS_DATA_OFS:
				rdata[7:0] = shift_data_reg;
			`TWS_OWNADDR_OFS:
				rdata[7:0] = own_slave_address;
			`TWS_POWER_OFS:
				rdata[1:0] = {wake_reg, deep_sleep_reg};
			default:
				addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end
		else
		begin
			pready_reg  <= psel & ~penable;
			pslverr_reg <= psel & ~penable & ~addr_ok;
			if (psel && !penable)
				prdata_reg <= rdata;
		end
	end

	// Software-owned configuration; start request is dropped once the START is on the bus
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_enable        <= ctrl_rst_val[`TWS_CTRL_ACK];
			start_request     <= ctrl_rst_val[`TWS_CTRL_STA];
			stop_request      <= ctrl_rst_val[`TWS_CTRL_STO];
			iface_enable      <= ctrl_rst_val[`TWS_CTRL_EN];
			irq_enable        <= ctrl_rst_val[`TWS_CTRL_IE];
			own_slave_address <= `TWS_OWNADDR_RESET;
			presc_reg         <= `TWS_PRESC_RESET;
			deep_sleep_reg    <= 1'b0;
		end
		else
		begin
			if (start_done_reg)
				start_request <= 1'b0;
			if (apb_wr && paddr == `TWS_CTRL_OFS)
			begin
				ack_enable    <= pwdata[`TWS_CTRL_ACK];
				start_request <= pwdata[`TWS_CTRL_STA];
				stop_request  <= pwdata[`TWS_CTRL_STO];
				iface_enable  <= pwdata[`TWS_CTRL_EN];
				irq_enable    <= pwdata[`TWS_CTRL_IE];
			end
			if (apb_wr && paddr == `TWS_STATUS_OFS)
				presc_reg <= pwdata[1:0];
			if (apb_wr && paddr == `TWS_OWNADDR_OFS)
				own_slave_address <= pwdata[7:0];
			if (apb_wr && paddr == `TWS_POWER_OFS)
				deep_sleep_reg <= pwdata[`TWS_PWR_SLEEP];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bus_busy_reg <= 1'b0;
		else if (line_bus.start_det)
			bus_busy_reg <= 1'b1;
		else if (line_bus.stop_det)
			bus_busy_reg <= 1'b0;
	end

	// Arbitration loss is remembered until the next acknowledged address phase ends or the bus stops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lost_reg <= 1'b0;
		else if (arb_lost)
			lost_reg <= 1'b1;
		else if (line_bus.stop_det || (state_reg == ST_ADDR_ACK && line_bus.scl_fall))
			lost_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			write_collision_flag <= 1'b0;
			wake_reg             <= 1'b0;
		end
		else
		begin
			if (apb_wr && paddr == `TWS_DATA_OFS)
				write_collision_flag <= !service_flag;
			if (state_reg == ST_ADDR_ACK && line_bus.scl_fall && deep_sleep_reg)
				wake_reg <= 1'b1;
			else if (!deep_sleep_reg)
				wake_reg <= 1'b0;
		end
	end

	// Bus protocol engine; a hardware set of the service flag wins over a software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg       <= ST_IDLE;
			shift_reg       <= 8'h00;
			shift_data_reg  <= `TWS_DATA_RESET;
			status_code_reg <= 5'(`TWS_ST_IDLE >> 3);
			bit_cnt_reg     <= 4'h0;
			hold_cnt_reg    <= 6'h00;
			service_flag    <= 1'b0;
			gc_reg          <= 1'b0;
			data_ack_reg    <= 1'b0;
			nack_last_reg   <= 1'b0;
			mst_reg         <= 1'b0;
			start_done_reg  <= 1'b0;
			sda_oe          <= 1'b0;
			scl_oe          <= 1'b0;
		end
		else
		begin
			start_done_reg <= 1'b0;
			if (flag_clr)
				service_flag <= 1'b0;
			if (apb_wr && paddr == `TWS_DATA_OFS && service_flag)
				shift_data_reg <= pwdata[7:0];
			if (!iface_enable)
			begin
				state_reg <= ST_IDLE;
				sda_oe    <= 1'b0;
				scl_oe    <= 1'b0;
			end
			else if (line_bus.start_det && state_reg != ST_START_GEN && state_reg != ST_WAIT_SVC)
			begin
				if (state_reg == ST_DATA)
				begin
					service_flag    <= 1'b1;
					status_code_reg <= 5'(`TWS_ST_STOP >> 3);
				end
				state_reg   <= ST_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe      <= 1'b0;
			end
			else if (line_bus.stop_det && state_reg != ST_START_GEN && state_reg != ST_WAIT_SVC)
			begin
				if (state_reg == ST_DATA)
				begin
					service_flag    <= 1'b1;
					status_code_reg <= 5'(`TWS_ST_STOP >> 3);
				end
				state_reg <= ST_IDLE;
				sda_oe    <= 1'b0;
			end
			else
			begin
				case (state_reg)
					ST_IDLE:
						if (start_request && !service_flag)
							state_reg <= ST_START_GEN;
					ST_ADDR, ST_DATA:
						if (line_bus.scl_rise && bit_cnt_reg != 4'h8)
						begin
							shift_reg   <= {shift_reg[6:0], line_bus.sda};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (line_bus.scl_fall && bit_cnt_reg == 4'h8)
						begin
							if (state_reg == ST_ADDR)
							begin
								// Direction 1 belongs to the transmitter path; here it means not addressed
								if ((own_hit || gc_hit) && !shift_reg[0])
								begin
									gc_reg    <= !own_hit;
									sda_oe    <= 1'b1;
									state_reg <= ST_ADDR_ACK;
								end
								else
									state_reg <= ST_IDLE;
							end
							else
							begin
								data_ack_reg <= ack_enable;
								sda_oe       <= ack_enable;
								if (!deep_sleep_reg)
									shift_data_reg <= shift_reg;
								state_reg <= ST_DATA_ACK;
							end
						end
					ST_ADDR_ACK:
						if (line_bus.scl_fall)
						begin
							sda_oe        <= 1'b0;
							scl_oe        <= 1'b1;
							service_flag  <= 1'b1;
							nack_last_reg <= 1'b0;
							if (gc_reg)
								status_code_reg <= 5'((lost_reg ? `TWS_ST_ARB_GC : `TWS_ST_GC_ACK) >> 3);
							else
								status_code_reg <= 5'((lost_reg ? `TWS_ST_ARB_OWN : `TWS_ST_OWN_ACK) >> 3);
							state_reg <= ST_WAIT_SVC;
						end
					ST_DATA_ACK:
						if (line_bus.scl_fall)
						begin
							sda_oe        <= 1'b0;
							scl_oe        <= 1'b1;
							service_flag  <= 1'b1;
							nack_last_reg <= !data_ack_reg;
							if (gc_reg)
								status_code_reg <= 5'((data_ack_reg ? `TWS_ST_GCD_ACK : `TWS_ST_GCD_NACK) >> 3);
							else
								status_code_reg <= 5'((data_ack_reg ? `TWS_ST_DATA_ACK : `TWS_ST_DATA_NACK) >> 3);
							state_reg <= ST_WAIT_SVC;
						end
					ST_WAIT_SVC:
						if (!service_flag)
						begin
							scl_oe          <= 1'b0;
							sda_oe          <= 1'b0;
							status_code_reg <= 5'(`TWS_ST_IDLE >> 3);
							bit_cnt_reg     <= 4'h0;
							mst_reg         <= 1'b0;
							if (mst_reg)
								state_reg <= ST_IDLE;
							else if (nack_last_reg)
								state_reg <= start_request ? ST_START_GEN : ST_IDLE;
							else
								state_reg <= ST_DATA;
						end
					ST_START_GEN:
						if (!sda_oe)
						begin
							if (bus_free)
							begin
								sda_oe       <= 1'b1;
								hold_cnt_reg <= 6'(`TWS_START_HOLD_CYC - 1);
							end
						end
						else if (hold_cnt_reg != 6'h00)
							hold_cnt_reg <= hold_cnt_reg - 6'h01;
						else
						begin
							scl_oe          <= 1'b1;
							service_flag    <= 1'b1;
							status_code_reg <= 5'(`TWS_ST_START >> 3);
							start_done_reg  <= 1'b1;
							mst_reg         <= 1'b1;
							state_reg       <= ST_WAIT_SVC;
						end
					default:
						state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// Open-drain outputs only ever pull low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
		else
		begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end

	assign prdata   = prdata_reg;
	assign pready   = pready_reg;
	assign pslverr  = pslverr_reg;
	assign wake_req = wake_reg;

endmodule

`default_nettype wire

// ==== verification/tws_slave_rx_chk.sv ====
// Concurrent checks on the slave receiver ports
`timescale 1ns/1ns
`default_nettype none

module tws_slave_rx_chk
(
	// APB slave
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic		pready,
	input wire logic		pslverr,
	// Two-wire bus
	input wire logic		scl_i,
	input wire logic		scl_o,
	input wire logic		scl_oe,
	input wire logic		sda_i,
	input wire logic		sda_o,
	input wire logic		sda_oe,
	// Master logic and power
	input wire logic		arb_lost,
	input wire logic		wake_req
);
	logic	wr_clr;
	logic	wr_keep;

	assign wr_clr = psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[7];
	assign wr_keep = psel && penable && pready && pwrite && paddr == 8'h00 && !pwdata[7];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_slverr_map: assert property (pready && paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10} |-> !pslverr)
		else $error("error on mapped address");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_open_drain: assert property (!scl_o && !sda_o)
		else $error("line driven high");
	a_release_clear: assert property ($fell(scl_oe) |-> $past(wr_clr) || $past(wr_clr, 2) || $past(wr_clr, 3))
		else $error("clock released without flag clear");
	a_flag_keep: assert property (scl_oe && wr_keep && !$past(wr_clr) && !$past(wr_clr, 2) && !$past(wr_clr, 3)
		|=> scl_oe)
		else $error("zero write released clock");
	a_ack_len: assert property ($rose(sda_oe) |-> sda_oe [*6])
		else $error("data line pulse too short");
	a_wake_stretch: assert property ($rose(wake_req) |-> ##[0:24] scl_oe)
		else $error("wake without clock hold");
endmodule

bind tws_slave_rx tws_slave_rx_chk tws_slave_rx_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .arb_lost(arb_lost), .wake_req(wake_req));

`default_nettype wire

// ==== verification/tws_bus_master.sv ====
// Behavioural two-wire master transmitter with clock stretch support
`timescale 1ns/1ns
`default_nettype none

module tws_bus_master
(
	// Resolved bus lines
	input wire logic	scl,
	input wire logic	sda,
	// High pulls the line low
	output logic		scl_dn,
	output logic		sda_dn
);
	localparam int HALF = 400;

	initial
	begin
		scl_dn = 1'b0;
		sda_dn = 1'b0;
	end

	// Waits out a slave stretch so the high phase is never cut short
	task automatic rise();
		scl_dn = 1'b0;
		wait (scl === 1'b1);
		#HALF;
	endtask

	task automatic start_c();
		sda_dn = 1'b0;
		scl_dn = 1'b0;
		#HALF;
		sda_dn = 1'b1;
		#HALF;
		scl_dn = 1'b1;
	endtask

	// Data moves well after the fall so no false start or stop is seen
	task automatic send_byte(input logic [7:0] b, output logic ak);
		for (int i = 7; i >= 0; i--)
		begin
			#100;
			sda_dn = ~b[i];
			#(HALF - 100);
			rise();
			scl_dn = 1'b1;
		end
		#100;
		sda_dn = 1'b0;
		#(HALF - 100);
		scl_dn = 1'b0;
		wait (scl === 1'b1);
		#(HALF / 2);
		ak = sda;
		#(HALF / 2);
		scl_dn = 1'b1;
	endtask

	task automatic stop_c();
		#100;
		sda_dn = 1'b1;
		#(HALF - 100);
		rise();
		sda_dn = 1'b0;
		#HALF;
	endtask
endmodule

`default_nettype wire

// ==== verification/tws_slave_rx_tb.sv ====
// Self-checking bench for the two-wire slave receiver
`timescale 1ns/1ns
`default_nettype none

module tws_slave_rx_tb;
	logic			pclk, presetn, psel, penable, pwrite, arb_lost, ak, rerr;
	logic			pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, wake_req, scl_dn, sda_dn, scl_w, sda_w;
	logic [7:0]		paddr;
	logic [6:0]		own;
	logic [31:0]	pwdata, prdata, rdat;
	logic [7:0]		rst_val [4] = '{8'h00, 8'hf8, 8'hff, 8'h00};
	logic [7:0]		dq [$];
	int				bad_count, n_checks, seed;

	assign scl_w = ~(scl_oe | scl_dn);
	assign sda_w = ~(sda_oe | sda_dn);

	tws_slave_rx tws_slave_rx_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.arb_lost(arb_lost), .wake_req(wake_req));
	tws_bus_master tws_bus_master_inst (.scl(scl_w), .sda(sda_w), .scl_dn(scl_dn), .sda_dn(sda_dn));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'($random(seed)), d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 16);
		if (n == 16)
		begin
			bad_count++;
			$display("unexpected at %0t: no ready from the register bus", $time);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic svc_wait();
		int n = 0;
		do
			apb(1'b0, 8'h00, 8'h00);
		while (rdat[7] !== 1'b1 && ++n < 100);
		chk({7'h0, rdat[7]}, 8'h01);
	endtask

	task automatic stat(input logic [7:0] exp);
		apb(1'b0, 8'h04, 8'h00);
		chk(rdat[7:0] & 8'hf8, exp);
	endtask

	task automatic run(input logic gc, input logic arb, input logic slp, input logic [7:0] svc);
		logic [7:0] d;
		if (slp)
			apb(1'b1, 8'h10, 8'h01);
		@(posedge pclk);
		arb_lost <= arb;
		tws_bus_master_inst.start_c();
		tws_bus_master_inst.send_byte(gc ? 8'h00 : {own, 1'b0}, ak);
		chk({7'h0, ak}, 8'h00);
		svc_wait();
		arb_lost <= 1'b0;
		chk({5'h0, wake_req, scl_oe, scl_w}, {5'h0, slp, 2'b10});
		if (slp)
			apb(1'b1, 8'h10, 8'h00);
		stat(gc ? (arb ? 8'h78 : 8'h70) : (arb ? 8'h68 : 8'h60));
		apb(1'b1, 8'h00, 8'h44);
		apb(1'b0, 8'h00, 8'h00);
		chk(rdat[7:0] & 8'h80, 8'h80);
		d = 8'($random(seed));
		dq.push_back(d);
		apb(1'b1, 8'h00, 8'hc4);
		tws_bus_master_inst.send_byte(d, ak);
		chk({7'h0, ak}, 8'h00);
		svc_wait();
		stat(gc ? 8'h90 : 8'h80);
		apb(1'b0, 8'h08, 8'h00);
		chk(rdat[7:0], dq.pop_front());
		apb(1'b1, 8'h00, 8'h84);
		tws_bus_master_inst.send_byte(8'($random(seed)), ak);
		chk({7'h0, ak}, 8'h01);
		svc_wait();
		stat(gc ? 8'h98 : 8'h88);
		apb(1'b1, 8'h00, svc);
		tws_bus_master_inst.stop_c();
		if (svc[5])
		begin
			svc_wait();
			stat(8'h08);
			apb(1'b1, 8'h00, 8'hc4);
		end
		$display("done run gc %0d arb %0d sleep %0d", gc, arb, slp);
	endtask

	// Address that must be ignored: no acknowledge and no flag
	task automatic probe(input logic [7:0] ab);
		tws_bus_master_inst.start_c();
		tws_bus_master_inst.send_byte(ab, ak);
		tws_bus_master_inst.stop_c();
		chk({7'h0, ak}, 8'h01);
		apb(1'b0, 8'h00, 8'h00);
		chk(rdat[7:0] & 8'h80, 8'h00);
	endtask

	initial
	begin
		#5000000;
		bad_count++;
		print_verdict();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		arb_lost = 1'b0;
		bad_count = 0;
		n_checks = 0;
		seed = 32'h2067;
		own = 7'($random(seed)) | 7'h08;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'(i * 4), 8'h00);
			chk(rdat[7:0], rst_val[i]);
		end
		apb(1'b0, 8'h14, 8'h00);
		chk({7'h0, rerr}, 8'h01);
		$display("done reset values");
		apb(1'b1, 8'h0c, {own, 1'b1});
		apb(1'b1, 8'h00, 8'h44);
		run(1'b0, 1'b0, 1'b0, 8'hc4);
		run(1'b1, 1'b0, 1'b0, 8'he4);
		run(1'b0, 1'b1, 1'b0, 8'hc4);
		run(1'b1, 1'b1, 1'b0, 8'hc4);
		run(1'b0, 1'b0, 1'b1, 8'hc4);
		probe({own ^ 7'h01, 1'b0});
		probe({own, 1'b1});
		apb(1'b1, 8'h0c, {own, 1'b0});
		probe(8'h00);
		apb(1'b1, 8'h00, 8'h04);
		probe({own, 1'b0});
		apb(1'b1, 8'h00, 8'h44);
		run(1'b0, 1'b0, 1'b0, 8'hc4);
		$display("done refusals");
		print_verdict();
	end
endmodule

`default_nettype wire
